//--- hw/partial_empty_threshold_regs.sv
// Partially-empty threshold registers with flag generation and interrupts.
// Assumes a classic Wishbone master and fill levels synchronous to ref_clk.
// Assumes software loads the intended threshold defaults after reset.
// Overview of operation
// - First threshold held as 22-bit value
// - Intended default one eightieth of capacity
// - First threshold drives flag A or channel 0
// - High byte low six bits hold 21:16
// - Middle byte holds bits 15:8
// - Second threshold held as 18-bit value
// - Second threshold used only in dual mode
// - Intended default one eightieth channel capacity
// - Register 10 low bits hold 17:16
// - Register 11 holds bits 15:8
// - Register 12 holds bits 7:0
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module partial_empty_threshold_regs #(
	parameter int LEVEL_A_WIDTH = 22,
	parameter int LEVEL_B_WIDTH = 18
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Fill levels from the pointer logic
	input wire logic [LEVEL_A_WIDTH-1:0] fillLevelA,
	input wire logic [LEVEL_B_WIDTH-1:0] fillLevelB,
	// Thresholds and flags
	output logic [LEVEL_A_WIDTH-1:0] empty_limit_a_value,
	output logic [LEVEL_B_WIDTH-1:0] empty_limit_b_value,
	output logic partial_empty_flag_a,
	output logic partial_empty_flag_b,
	output logic irq
);
	logic [pe_limit_pkg::A_HIGH_BITS-1:0] limitAHigh;
	logic [7:0] limitAMiddle;
	logic [7:0] limitALow;
	logic [pe_limit_pkg::B_HIGH_BITS-1:0] limitBHigh;
	logic [7:0] limitBMiddle;
	logic [7:0] limitBLow;
	logic [1:0] channelMode;
	logic [pe_limit_pkg::EV_BITS-1:0] status;
	logic [pe_limit_pkg::EV_BITS-1:0] mask;
	logic [pe_limit_pkg::EV_BITS-1:0] events;
	logic flagAPrev;
	logic flagBPrev;
	logic flagA;
	logic flagB;
	logic dualMode;
	logic request;
	logic writeStrobe;
	logic [7:0] regIndex;
	// Bus decode
	logic taken;
	logic [31:0] next_readData;
	// Per-register write enables
	logic writeAHigh;
	logic writeAMiddle;
	logic writeALow;
	logic writeBHigh;
	logic writeBMiddle;
	logic writeBLow;
	logic writeMode;
	logic writeMask;
	logic clearStatus;
	// Status update
	logic [pe_limit_pkg::EV_BITS-1:0] next_status;

	// Bus answer states
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} busState_t;

	busState_t busState;
	busState_t next_busState;

	// Index from word address; byte address bits [1:0] are ignored
	function automatic logic [7:0] word_index(input logic [9:0] adr);
		word_index = adr[9:2];
	endfunction : word_index

	function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
		hit = (idx == target);
	endfunction : hit

	assign request = wb_cyc_i && wb_stb_i;
	assign taken = request && (busState == BUS_IDLE);
	assign regIndex = word_index(wb_adr_i);
	assign writeStrobe = taken && wb_we_i && wb_sel_i[0];
	assign dualMode = (channelMode == pe_limit_pkg::MODE_DUAL);

	// One write enable per register; the bytes are independent, with no atomic latch
	assign writeAHigh = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_A_HIGH);
	assign writeAMiddle = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_A_MIDDLE);
	assign writeALow = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_A_LOW);
	assign writeBHigh = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_B_HIGH);
	assign writeBMiddle = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_B_MIDDLE);
	assign writeBLow = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_B_LOW);

	// Control and interrupt registers
	assign writeMode = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_MODE);
	assign writeMask = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_MASK);
	assign clearStatus = writeStrobe && hit(regIndex, pe_limit_pkg::IDX_STATUS);

	// Answer one cycle after the request is taken, then idle for one cycle
	always_comb begin
		next_busState = busState;
		unique case (busState)
			BUS_IDLE: begin
				if (request) begin
					next_busState = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_busState = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busState <= BUS_IDLE;
		end else begin
			busState <= next_busState;
		end
	end

	// Ack comes straight from the state flip-flop
	assign wb_ack_o = (busState == BUS_ANSWER);

	// Threshold A bytes; reserved high bits of the top byte are not stored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			limitAHigh <= pe_limit_pkg::REG_RESET[pe_limit_pkg::A_HIGH_BITS-1:0];
			limitAMiddle <= pe_limit_pkg::REG_RESET;
			limitALow <= pe_limit_pkg::REG_RESET;
		end else if (writeStrobe) begin
			if (writeAHigh) begin
				limitAHigh <= wb_dat_i[pe_limit_pkg::A_HIGH_BITS-1:0];
			end
			if (writeAMiddle) begin
				limitAMiddle <= wb_dat_i[7:0];
			end
			if (writeALow) begin
				limitALow <= wb_dat_i[7:0];
			end
		end
	end

	// Threshold B bytes; software keeps reserved bits zero, hardware drops them
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			limitBHigh <= pe_limit_pkg::REG_RESET[pe_limit_pkg::B_HIGH_BITS-1:0];
			limitBMiddle <= pe_limit_pkg::REG_RESET;
			limitBLow <= pe_limit_pkg::REG_RESET;
		end else if (writeStrobe) begin
			if (writeBHigh) begin
				limitBHigh <= wb_dat_i[pe_limit_pkg::B_HIGH_BITS-1:0];
			end
			if (writeBMiddle) begin
				limitBMiddle <= wb_dat_i[7:0];
			end
			if (writeBLow) begin
				limitBLow <= wb_dat_i[7:0];
			end
		end
	end

	// Channel mode; code 3 is kept but treated as not dual
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			channelMode <= pe_limit_pkg::MODE_SINGLE;
		end else if (writeMode) begin
			channelMode <= wb_dat_i[1:0];
		end
	end

	// Interrupt mask, same layout as the status register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mask <= '0;
		end else if (writeMask) begin
			mask <= wb_dat_i[pe_limit_pkg::EV_BITS-1:0];
		end
	end

	// Assembled thresholds; the intended defaults are loaded by software
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			empty_limit_a_value <= '0;
			empty_limit_b_value <= '0;
		end else begin
			empty_limit_a_value <= {limitAHigh, limitAMiddle, limitALow};
			empty_limit_b_value <= {limitBHigh, limitBMiddle, limitBLow};
		end
	end

	// Flag A governs single, cascade, or channel 0 in dual mode
	pe_flag_compare #(
		.WIDTH(LEVEL_A_WIDTH)
	) compareA (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(1'b1),
		.fillLevel(fillLevelA),
		.limit(empty_limit_a_value),
		.flag(flagA)
	);

	// Flag B only in dual mode
	pe_flag_compare #(
		.WIDTH(LEVEL_B_WIDTH)
	) compareB (
		.ref_clk(ref_clk),
		.rst(rst),
		.enable(dualMode),
		.fillLevel(fillLevelB),
		.limit(empty_limit_b_value),
		.flag(flagB)
	);

	assign partial_empty_flag_a = flagA;
	assign partial_empty_flag_b = flagB;

	// Edge events of both flags
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flagAPrev <= 1'b0;
			flagBPrev <= 1'b0;
		end else begin
			flagAPrev <= flagA;
			flagBPrev <= flagB;
		end
	end

	always_comb begin
		events = '0;
		events[pe_limit_pkg::EV_A_SET] = flagA && !flagAPrev;
		events[pe_limit_pkg::EV_A_CLR] = !flagA && flagAPrev;
		events[pe_limit_pkg::EV_B_SET] = flagB && !flagBPrev;
		events[pe_limit_pkg::EV_B_CLR] = !flagB && flagBPrev;
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_comb begin
		next_status = status | events;
		if (clearStatus) begin
			next_status = (status & ~wb_dat_i[pe_limit_pkg::EV_BITS-1:0]) | events;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status <= '0;
		end else begin
			status <= next_status;
		end
	end

	// Interrupt level from a flip-flop, one cycle behind status and mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// Read word for the addressed register; unmapped reads as zero
	always_comb begin
		next_readData = 32'h0000_0000;
		unique case (regIndex)
			pe_limit_pkg::IDX_A_HIGH: next_readData = {26'h0, limitAHigh};
			pe_limit_pkg::IDX_A_MIDDLE: next_readData = {24'h0, limitAMiddle};
			pe_limit_pkg::IDX_A_LOW: next_readData = {24'h0, limitALow};
			pe_limit_pkg::IDX_B_HIGH: next_readData = {30'h0, limitBHigh};
			pe_limit_pkg::IDX_B_MIDDLE: next_readData = {24'h0, limitBMiddle};
			pe_limit_pkg::IDX_B_LOW: next_readData = {24'h0, limitBLow};
			pe_limit_pkg::IDX_MODE: next_readData = {30'h0, channelMode};
			pe_limit_pkg::IDX_STATUS: next_readData = {28'h0, status};
			pe_limit_pkg::IDX_MASK: next_readData = {28'h0, mask};
			pe_limit_pkg::IDX_LEVEL: next_readData = {30'h0, flagB, flagA};
			default: next_readData = 32'h0000_0000;
		endcase
	end

	// Read data loaded when the request is taken and held through the ack
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (taken) begin
			wb_dat_o <= next_readData;
		end
	end
endmodule : partial_empty_threshold_regs
`default_nettype wire

//--- hw/pe_limit_pkg.sv
// Package for the partially-empty threshold register block.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package pe_limit_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_A_HIGH = 8'h0D;
	localparam logic [7:0] IDX_A_MIDDLE = 8'h0E;
	localparam logic [7:0] IDX_A_LOW = 8'h0F;
	localparam logic [7:0] IDX_B_HIGH = 8'h10;
	localparam logic [7:0] IDX_B_MIDDLE = 8'h11;
	localparam logic [7:0] IDX_B_LOW = 8'h12;
	localparam logic [7:0] IDX_MODE = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h21;
	localparam logic [7:0] IDX_MASK = 8'h22;
	localparam logic [7:0] IDX_LEVEL = 8'h23;
	localparam int LIMIT_A_WIDTH = 22;
	localparam int LIMIT_B_WIDTH = 18;
	localparam int A_HIGH_BITS = 6;
	localparam int B_HIGH_BITS = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Channel modes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CASCADE = 2'h1;
	localparam logic [1:0] MODE_DUAL = 2'h2;
	// Status / mask bit positions
	localparam int EV_A_SET = 0;
	localparam int EV_A_CLR = 1;
	localparam int EV_B_SET = 2;
	localparam int EV_B_CLR = 3;
	localparam int EV_BITS = 4;
	// Level register bit positions
	localparam int LV_FLAG_A = 0;
	localparam int LV_FLAG_B = 1;
endpackage : pe_limit_pkg

//--- hw/pe_flag_compare.sv
// Partially-empty flag comparator: registered flag of level against limit.
// Assumes the fill level is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pe_flag_compare #(
	parameter int WIDTH = 22
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Comparison
	input wire logic enable,
	input wire logic [WIDTH-1:0] fillLevel,
	input wire logic [WIDTH-1:0] limit,
	output logic flag
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag <= 1'b0;
		end else begin
			flag <= enable && (fillLevel <= limit);
		end
	end
endmodule : pe_flag_compare
`default_nettype wire

//--- sim/pe_limit_assertions.sv
// Checker for the threshold register block, seeing only its ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module pe_limit_checker #(
	parameter int LEVEL_A_WIDTH = 22,
	parameter int LEVEL_B_WIDTH = 18
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	// Levels, limits and flags
	input wire logic [LEVEL_A_WIDTH-1:0] fillLevelA,
	input wire logic [LEVEL_A_WIDTH-1:0] empty_limit_a_value,
	input wire logic [LEVEL_B_WIDTH-1:0] fillLevelB,
	input wire logic [LEVEL_B_WIDTH-1:0] empty_limit_b_value,
	input wire logic partial_empty_flag_a,
	input wire logic partial_empty_flag_b,
	input wire logic irq
);
	wire logic wr = wb_ack_o && wb_we_i && wb_sel_i[0];
	wire logic [7:0] ix = wb_adr_i[9:2];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_high_a: assert property (wr && ix == pe_limit_pkg::IDX_A_HIGH
		|=> empty_limit_a_value[21:16] == $past(wb_dat_i[5:0])) else $error("limit A high bits wrong");
	a_mid_a: assert property (wr && ix == pe_limit_pkg::IDX_A_MIDDLE
		|=> empty_limit_a_value[15:8] == $past(wb_dat_i[7:0])) else $error("limit A middle byte wrong");
	b_high_a: assert property (wr && ix == pe_limit_pkg::IDX_B_HIGH
		|=> empty_limit_b_value[17:16] == $past(wb_dat_i[1:0])) else $error("limit B high bits wrong");
	b_mid_a: assert property (wr && ix == pe_limit_pkg::IDX_B_MIDDLE
		|=> empty_limit_b_value[15:8] == $past(wb_dat_i[7:0])) else $error("limit B middle byte wrong");
	b_low_a: assert property (wr && ix == pe_limit_pkg::IDX_B_LOW
		|=> empty_limit_b_value[7:0] == $past(wb_dat_i[7:0])) else $error("limit B low byte wrong");
	a_hold_a: assert property (!wr |=> $stable(empty_limit_a_value)) else $error("limit A moved");
	b_hold_a: assert property (!wr |=> $stable(empty_limit_b_value)) else $error("limit B moved");
	flag_a_a: assert property (!$past(rst)
		|-> partial_empty_flag_a == $past(fillLevelA <= empty_limit_a_value)) else $error("flag A wrong");
	flag_b_a: assert property (partial_empty_flag_b && !$past(rst)
		|-> $past(fillLevelB <= empty_limit_b_value)) else $error("flag B without cause");
	cover property (wr);
	cover property ($rose(partial_empty_flag_b));
	cover property ($rose(irq));
endmodule : pe_limit_checker
bind partial_empty_threshold_regs pe_limit_checker #(
	.LEVEL_A_WIDTH(LEVEL_A_WIDTH),
	.LEVEL_B_WIDTH(LEVEL_B_WIDTH)
) chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.fillLevelA(fillLevelA),
	.empty_limit_a_value(empty_limit_a_value),
	.fillLevelB(fillLevelB),
	.empty_limit_b_value(empty_limit_b_value),
	.partial_empty_flag_a(partial_empty_flag_a),
	.partial_empty_flag_b(partial_empty_flag_b),
	.irq(irq)
);
`default_nettype wire

//--- sim/tb_partial_empty_threshold_regs.sv
// Bench for the threshold registers: Wishbone accesses and flag checks.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_partial_empty_threshold_regs;
	logic ref_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [9:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = '0, wb_dat_o, q;
	logic wb_ack_o, partial_empty_flag_a, partial_empty_flag_b, irq;
	logic [21:0] fillLevelA = 22'h3FFFFF, empty_limit_a_value;
	logic [17:0] fillLevelB = 18'h3FFFF, empty_limit_b_value;
	logic [7:0] rl [8] = '{8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h21, 8'h22, 8'h3F};
	int fails = 0, samples_checked = 0;
	partial_empty_threshold_regs uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.fillLevelA(fillLevelA),
		.fillLevelB(fillLevelB),
		.empty_limit_a_value(empty_limit_a_value),
		.empty_limit_b_value(empty_limit_b_value),
		.partial_empty_flag_a(partial_empty_flag_a),
		.partial_empty_flag_b(partial_empty_flag_b),
		.irq(irq)
	);
	initial forever #12.5 ref_clk = ~ref_clk;
	task automatic finish_test;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One classic cycle, held until ack is sampled high
	task automatic acc(input logic w, input logic [7:0] ix, d);
		int n;
		n = 0;
		wb_we_i <= w;
		wb_adr_i <= {ix, 2'h0};
		wb_dat_i <= {24'h0, d};
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		if (wb_ack_o !== 1'b1) begin
			fails++;
			$display("CHECK FAILED at %0t: no ack on the register bus", $time);
			finish_test;
		end else begin
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : acc
	task automatic wr(input logic [7:0] ix, d);
		acc(1'b1, ix, d);
	endtask : wr
	task automatic rd(input logic [7:0] ix, input logic [31:0] exp);
		acc(1'b0, ix, 8'h00);
		chk(q, exp);
	endtask : rd
	task automatic w3;
		repeat (3) @(posedge ref_clk);
	endtask : w3
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (rl[i]) rd(rl[i], 32'h0);
		wr(8'h0D, 8'hFF);
		wr(8'h0E, 8'hA5);
		wr(8'h0F, 8'h5A);
		wr(8'h10, 8'h03);
		wr(8'h11, 8'h12);
		wr(8'h12, 8'h34);
		rd(8'h0D, 32'h3F);
		rd(8'h0E, 32'hA5);
		rd(8'h0F, 32'h5A);
		rd(8'h10, 32'h03);
		rd(8'h11, 32'h12);
		rd(8'h12, 32'h34);
		wb_sel_i <= 4'hE;
		wr(8'h12, 8'hFF);
		wb_sel_i <= 4'hF;
		rd(8'h12, 32'h34);
		chk({10'h0, empty_limit_a_value}, 32'h3FA55A);
		chk({14'h0, empty_limit_b_value}, 32'h31234);
		fillLevelA <= 22'h3FA55A;
		w3;
		chk(partial_empty_flag_a, 1'b1);
		rd(8'h21, 32'h1);
		chk(irq, 1'b0);
		wr(8'h22, 8'h01);
		chk(irq, 1'b1);
		wr(8'h21, 8'h01);
		chk(irq, 1'b0);
		fillLevelA <= 22'h3FA55B;
		w3;
		chk(partial_empty_flag_a, 1'b0);
		rd(8'h21, 32'h2);
		fillLevelB <= 18'h31234;
		w3;
		chk(partial_empty_flag_b, 1'b0);
		wr(8'h20, 8'h02);
		w3;
		chk(partial_empty_flag_b, 1'b1);
		fillLevelB <= 18'h31235;
		w3;
		chk(partial_empty_flag_b, 1'b0);
		fillLevelB <= 18'h0;
		wr(8'h20, 8'h01);
		fillLevelA <= 22'h0;
		w3;
		chk(partial_empty_flag_a, 1'b1);
		chk(partial_empty_flag_b, 1'b0);
		rd(8'h23, 32'h1);
		rd(8'h21, 32'hF);
		chk(irq, 1'b1);
		finish_test;
	end
endmodule : tb_partial_empty_threshold_regs
`default_nettype wire
